/* File: verilog/host_packet_link.sv */
// Summary of operation
// - Serial link starts at 115200 baud, 8 data bits, no parity, one stop.
// - A dedicated command switches the link to 19200 baud.
// - Packets go type byte, length byte, payload, then two CRC bytes.
// - Type byte holds class in top two bits, code 0-63 below.
// - Class 00 marks host commands, class 01 marks normal responses.
// - Unsolicited reports use class 10.
// - Well formed packets with illegal content get a class 11 error.
// - Length byte counts payload bytes and lies between 0 and 22.
// - Exactly as many payload bytes as the length byte says are sent.
// - CRC-16 covers type, length and payload, sent low byte first.
// - CRC follows the last used payload byte, no padding.
// - Accepted command packets are answered within 250 ms, except those arriving while an answer or host command is pending; dropped packets get no answer.
// - Reports may be sent any time no rate change is pending, interleaved with acknowledges.
// - Key, fan and temperature reports go out when enabled and new.
// - Answer code equals the low six bits of the command code.
// - Ping answer echoes length and up to 16 payload bytes.
`timescale 1ns/1ps
`default_nettype none
`include "host_link_defines.svh"
module host_packet_link import host_link_pkg::*; #(
    parameter int unsigned DIV_FAST = `BAUD_DIV_FAST,
    parameter int unsigned DIV_SLOW = `BAUD_DIV_SLOW,
    parameter int unsigned ANS_WAIT = `ANS_WAIT_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        rx_i,
    output logic             tx_o,
    output logic             cmd_valid_o,
    output logic [5:0]       cmd_code_o,
    output logic [4:0]       cmd_len_o,
    input  wire logic        ans_valid_i,
    input  wire logic        ans_ok_i,
    input  wire logic [2:0]  rpt_en_i,
    input  wire logic        rpt_valid_i,
    output logic             rpt_ready_o,
    input  wire logic [5:0]  rpt_code_i,
    input  wire logic [2:0]  rpt_len_i,
    input  wire logic [31:0] rpt_data_i,
    output logic             baud_slow_o,
    output logic             rx_drop_o
);
    // One bit of the reflected CRC per loop pass
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input byte_t b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    logic [2:0]  rx_s_q;
    logic        rx_lvl_q, baud_slow_q, baud_pend_q, baud_new_q;
    logic [15:0] bit_div;
    logic        rxb_busy_q, rx_stb_q;
    logic [15:0] rxb_cnt_q;
    logic [3:0]  rxb_bit_q;
    byte_t       rxb_sh_q;
    rx_state_t   rx_st_q;
    byte_t       rx_type_q, rx_crcl_q, rx_d0_q;
    logic [4:0]  rx_len_q, rx_idx_q;
    logic [15:0] rx_crc_q;
    logic        pkt_ok_q, rx_drop_q;
    logic        resp_pend_q, resp_mem_q, cmd_valid_q;
    byte_t       resp_type_q;
    logic [4:0]  resp_len_q;
    logic [5:0]  cmd_code_q;
    logic [4:0]  cmd_len_q;
    logic [25:0] tmr_q;
    tx_state_t   tx_st_q;
    byte_t       tx_type_q, tx_byte, mem_rd;
    logic [4:0]  tx_len_q, tx_idx_q;
    logic [15:0] tx_crc_q;
    logic        tx_mem_q, utx_busy_q, utx_load, resp_take, rpt_take;
    logic [31:0] tx_word_q;
    logic [15:0] utx_cnt_q;
    logic [3:0]  utx_bit_q;
    logic [9:0]  utx_sh_q;
    logic        buf_valid, rpt_en_hit, rpt_push_ok, rpt_in_ready;
    logic [40:0] buf_data;

    assign bit_div     = baud_slow_q ? 16'(DIV_SLOW) : 16'(DIV_FAST);
    assign tx_o        = utx_sh_q[0];
    assign baud_slow_o = baud_slow_q;
    assign rx_drop_o   = rx_drop_q;
    assign cmd_valid_o = cmd_valid_q;
    assign cmd_code_o  = cmd_code_q;
    assign cmd_len_o   = cmd_len_q;

    // Pin synchroniser and agreement filter
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_s_q   <= 3'h7;
            rx_lvl_q <= 1'b1;
        end else begin
            rx_s_q <= {rx_s_q[1:0], rx_i};
            if (rx_s_q[1] == rx_s_q[2]) begin
                rx_lvl_q <= rx_s_q[2];
            end
        end
    end

    // Receive bit timing, 8N1, sampled mid bit
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rxb_busy_q <= 1'b0;
            rxb_cnt_q  <= 16'h0000;
            rxb_bit_q  <= 4'h0;
            rxb_sh_q   <= 8'h00;
            rx_stb_q   <= 1'b0;
        end else begin
            rx_stb_q <= 1'b0;
            if (!rxb_busy_q) begin
                if (!rx_lvl_q) begin
                    rxb_busy_q <= 1'b1;
                    rxb_cnt_q  <= bit_div >> 1;
                    rxb_bit_q  <= 4'h0;
                end
            end else if (rxb_cnt_q != 16'h0000) begin
                rxb_cnt_q <= rxb_cnt_q - 16'h0001;
            end else begin
                rxb_cnt_q <= bit_div - 16'h0001;
                rxb_bit_q <= rxb_bit_q + 4'h1;
                if (rxb_bit_q == 4'h0 && rx_lvl_q) begin
                    rxb_busy_q <= 1'b0;  // False start
                end else if (rxb_bit_q == 4'h9) begin
                    rxb_busy_q <= 1'b0;
                    rx_stb_q   <= rx_lvl_q;  // Stop bit must be high
                end else if (rxb_bit_q != 4'h0) begin
                    rxb_sh_q <= {rx_lvl_q, rxb_sh_q[7:1]};
                end
            end
        end
    end

    // Packet framer on the receive side
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_st_q   <= R_TYPE;
            rx_type_q <= 8'h00;
            rx_len_q  <= 5'h00;
            rx_idx_q  <= 5'h00;
            rx_crc_q  <= `CRC_INIT;
            rx_crcl_q <= 8'h00;
            rx_d0_q   <= 8'h00;
            pkt_ok_q  <= 1'b0;
            rx_drop_q <= 1'b0;
        end else begin
            pkt_ok_q  <= 1'b0;
            rx_drop_q <= 1'b0;
            if (rx_stb_q) begin
                unique case (rx_st_q)
                    R_TYPE: begin
                        rx_type_q <= rxb_sh_q;
                        rx_crc_q  <= crc_step(`CRC_INIT, rxb_sh_q);
                        rx_st_q   <= R_LEN;
                    end
                    R_LEN: begin
                        rx_len_q <= rxb_sh_q[4:0];
                        rx_idx_q <= 5'h00;
                        rx_crc_q <= crc_step(rx_crc_q, rxb_sh_q);
                        if (rxb_sh_q > 8'(`MAX_PAYLOAD)) begin
                            rx_st_q   <= R_TYPE;
                            rx_drop_q <= 1'b1;
                        end else begin
                            rx_st_q <= (rxb_sh_q == 8'h00) ? R_CRCL : R_DATA;
                        end
                    end
                    R_DATA: begin
                        rx_crc_q <= crc_step(rx_crc_q, rxb_sh_q);
                        rx_idx_q <= rx_idx_q + 5'h01;
                        if (rx_idx_q == 5'h00) begin
                            rx_d0_q <= rxb_sh_q;
                        end
                        if (rx_idx_q == rx_len_q - 5'h01) begin
                            rx_st_q <= R_CRCL;
                        end
                    end
                    R_CRCL: begin
                        rx_crcl_q <= rxb_sh_q;
                        rx_st_q   <= R_CRCH;
                    end
                    R_CRCH: begin
                        rx_st_q <= R_TYPE;
                        if ({rxb_sh_q, rx_crcl_q} == ~rx_crc_q &&
                            rx_type_q[7:6] == `CLS_CMD) begin
                            pkt_ok_q <= 1'b1;
                        end else begin
                            rx_drop_q <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // Command dispatch, answer queue and deadline timer
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            resp_pend_q <= 1'b0;
            resp_mem_q  <= 1'b0;
            resp_type_q <= 8'h00;
            resp_len_q  <= 5'h00;
            cmd_valid_q <= 1'b0;
            cmd_code_q  <= 6'h00;
            cmd_len_q   <= 5'h00;
            tmr_q       <= 26'h0000000;
            baud_pend_q <= 1'b0;
            baud_new_q  <= 1'b0;
        end else begin
            if (resp_take) begin
                resp_pend_q <= 1'b0;
            end
            if (pkt_ok_q && !resp_pend_q && !cmd_valid_q) begin
                resp_mem_q <= 1'b0;
                resp_len_q <= 5'h00;
                if (rx_type_q[5:0] == `CODE_PING) begin
                    resp_pend_q <= 1'b1;
                    if (rx_len_q <= 5'(`PING_MAX)) begin
                        resp_type_q <= {`CLS_RESP, rx_type_q[5:0]};
                        resp_len_q  <= rx_len_q;
                        resp_mem_q  <= 1'b1;
                    end else begin
                        resp_type_q <= {`CLS_ERR, rx_type_q[5:0]};
                    end
                end else if (rx_type_q[5:0] == `CODE_BAUD) begin
                    resp_pend_q <= 1'b1;
                    if (rx_len_q == 5'h01 && rx_d0_q <= 8'h01) begin
                        resp_type_q <= {`CLS_RESP, rx_type_q[5:0]};
                        baud_pend_q <= 1'b1;
                        baud_new_q  <= rx_d0_q[0];
                    end else begin
                        resp_type_q <= {`CLS_ERR, rx_type_q[5:0]};
                    end
                end else begin
                    cmd_valid_q <= 1'b1;
                    cmd_code_q  <= rx_type_q[5:0];
                    cmd_len_q   <= rx_len_q;
                    tmr_q       <= 26'(ANS_WAIT - 1);
                end
            end else if (cmd_valid_q) begin
                if (ans_valid_i || tmr_q == 26'h0000000) begin
                    cmd_valid_q <= 1'b0;
                    resp_pend_q <= 1'b1;
                    resp_type_q <= {(ans_valid_i && ans_ok_i) ? `CLS_RESP
                                    : `CLS_ERR, cmd_code_q};
                end else begin
                    tmr_q <= tmr_q - 26'h0000001;
                end
            end
            if (baud_pend_q && !resp_pend_q && tx_st_q == T_IDLE &&
                !utx_busy_q) begin
                baud_pend_q <= 1'b0;
            end
        end
    end

    // Rate select, changed only once the acknowledge has left
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            baud_slow_q <= 1'b0;
        end else if (baud_pend_q && !resp_pend_q && tx_st_q == T_IDLE &&
                     !utx_busy_q) begin
            baud_slow_q <= baud_new_q;
        end
    end

    // Report intake, disabled items are swallowed
    assign rpt_en_hit  = (rpt_code_i < 6'(`RPT_ITEMS)) ?
                         rpt_en_i[rpt_code_i[1:0]] : 1'b1;
    assign rpt_push_ok = rpt_valid_i && rpt_en_hit &&
                         (rpt_len_i <= 3'(`RPT_MAX));
    assign rpt_ready_o = rpt_in_ready || !rpt_push_ok;

    skid_buffer #(.WIDTH(41), .DEPTH(2)) u_rpt_buf (
        .sys_clk_i   (sys_clk_i),
        .arst_n_i    (arst_n_i),
        .in_valid_i  (rpt_push_ok),
        .in_ready_o  (rpt_in_ready),
        .in_data_i   ({rpt_code_i, rpt_len_i, rpt_data_i}),
        .out_valid_o (buf_valid),
        .out_ready_i (rpt_take),
        .out_data_o  (buf_data)
    );

    payload_mem #(.DEPTH(`MAX_PAYLOAD), .AW(5)) u_payload (
        .sys_clk_i (sys_clk_i),
        .we_i      (rx_stb_q && rx_st_q == R_DATA),
        .waddr_i   (rx_idx_q),
        .wdata_i   (rxb_sh_q),
        .raddr_i   (tx_idx_q),
        .rdata_o   (mem_rd)
    );

    // Answers first, reports in the gaps between them
    assign resp_take = (tx_st_q == T_IDLE) && resp_pend_q && !baud_pend_q
                       || (tx_st_q == T_IDLE) && resp_pend_q && baud_pend_q;
    assign rpt_take  = (tx_st_q == T_IDLE) && !resp_pend_q && buf_valid &&
                       !baud_pend_q;
    assign utx_load  = !utx_busy_q && tx_st_q != T_IDLE;

    // Byte presented to the transmitter
    always_comb begin
        tx_byte = 8'h00;
        unique case (tx_st_q)
            T_IDLE: tx_byte = 8'h00;
            T_TYPE: tx_byte = tx_type_q;
            T_LEN:  tx_byte = {3'h0, tx_len_q};
            T_DATA: tx_byte = tx_mem_q ? mem_rd : tx_word_q[8*tx_idx_q[1:0] +: 8];
            T_CRCL: tx_byte = ~tx_crc_q[7:0];
            T_CRCH: tx_byte = ~tx_crc_q[15:8];
        endcase
    end

    // Packet framer on the transmit side
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_st_q   <= T_IDLE;
            tx_type_q <= 8'h00;
            tx_len_q  <= 5'h00;
            tx_idx_q  <= 5'h00;
            tx_crc_q  <= `CRC_INIT;
            tx_mem_q  <= 1'b0;
            tx_word_q <= 32'h00000000;
        end else if (resp_take) begin
            tx_st_q   <= T_TYPE;
            tx_type_q <= resp_type_q;
            tx_len_q  <= resp_len_q;
            tx_mem_q  <= resp_mem_q;
            tx_idx_q  <= 5'h00;
            tx_crc_q  <= `CRC_INIT;
        end else if (rpt_take) begin
            tx_st_q   <= T_TYPE;
            tx_type_q <= {`CLS_RPT, buf_data[40:35]};
            tx_len_q  <= {2'h0, buf_data[34:32]};
            tx_word_q <= buf_data[31:0];
            tx_mem_q  <= 1'b0;
            tx_idx_q  <= 5'h00;
            tx_crc_q  <= `CRC_INIT;
        end else if (utx_load) begin
            unique case (tx_st_q)
                T_TYPE: begin
                    tx_crc_q <= crc_step(tx_crc_q, tx_byte);
                    tx_st_q  <= T_LEN;
                end
                T_LEN: begin
                    tx_crc_q <= crc_step(tx_crc_q, tx_byte);
                    tx_st_q  <= (tx_len_q == 5'h00) ? T_CRCL : T_DATA;
                end
                T_DATA: begin
                    tx_crc_q <= crc_step(tx_crc_q, tx_byte);
                    tx_idx_q <= tx_idx_q + 5'h01;
                    if (tx_idx_q == tx_len_q - 5'h01) begin
                        tx_st_q <= T_CRCL;
                    end
                end
                T_CRCL: tx_st_q <= T_CRCH;
                T_CRCH: tx_st_q <= T_IDLE;
                T_IDLE: tx_st_q <= T_IDLE;
            endcase
        end
    end

    // Transmit bit timing: start, eight bits LSB first, stop
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            utx_busy_q <= 1'b0;
            utx_cnt_q  <= 16'h0000;
            utx_bit_q  <= 4'h0;
            utx_sh_q   <= 10'h3FF;
        end else if (utx_load) begin
            utx_busy_q <= 1'b1;
            utx_cnt_q  <= bit_div - 16'h0001;
            utx_bit_q  <= 4'h0;
            utx_sh_q   <= {1'b1, tx_byte, 1'b0};
        end else if (utx_busy_q) begin
            if (utx_cnt_q != 16'h0000) begin
                utx_cnt_q <= utx_cnt_q - 16'h0001;
            end else begin
                utx_cnt_q <= bit_div - 16'h0001;
                utx_bit_q <= utx_bit_q + 4'h1;
                utx_sh_q  <= {1'b1, utx_sh_q[9:1]};
                if (utx_bit_q == 4'h9) begin
                    utx_busy_q <= 1'b0;
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    chk_line_idle: assert property (!utx_busy_q |-> tx_o)
        else $error("line not idle high");
    chk_frame_bits: assert property (utx_load |=>
        !tx_o ##1 (!tx_o)[*1])
        else $error("start bit missing");
    chk_baud_safe: assert property ($changed(baud_slow_q) |->
        !$past(utx_busy_q) && $past(tx_st_q) == T_IDLE)
        else $error("rate changed mid packet");
    // A new packet may be taken while the last CRC byte still leaves
    chk_type_first: assert property ((resp_take || rpt_take) |=>
        tx_st_q == T_TYPE && tx_idx_q == 5'h00)
        else $error("packet did not open with type");
    chk_len_range: assert property (tx_st_q != T_IDLE |->
        tx_len_q <= 5'(`MAX_PAYLOAD))
        else $error("length above limit");
    chk_data_count: assert property (tx_st_q == T_DATA |->
        tx_idx_q < tx_len_q)
        else $error("payload overrun");
    chk_crc_order: assert property (utx_load &&
        tx_st_q == T_CRCL |=> tx_st_q == T_CRCH)
        else $error("crc bytes out of order");
    chk_resp_class: assert property (resp_take |=>
        tx_type_q[7:6] inside {`CLS_RESP, `CLS_ERR} &&
        tx_type_q == $past(resp_type_q))
        else $error("bad answer class");
    chk_rpt_class: assert property (rpt_take |=>
        tx_type_q[7:6] == `CLS_RPT)
        else $error("bad report class");
    chk_ans_deadline: assert property (cmd_valid_q &&
        tmr_q == '0 && !resp_take |=> !cmd_valid_q && resp_pend_q)
        else $error("answer deadline missed");
    chk_len_drop: assert property (rx_stb_q && rx_st_q == R_LEN &&
        rxb_sh_q > 8'(`MAX_PAYLOAD) |=> rx_st_q == R_TYPE && rx_drop_q)
        else $error("oversize length not dropped");

    cov_ping: cover property (resp_take && resp_mem_q);
    cov_report: cover property (rpt_take);
    cov_error: cover property (resp_take && resp_type_q[7:6] == `CLS_ERR);
    cov_baud: cover property ($rose(baud_slow_q));
endmodule // host_packet_link
`default_nettype wire

/* File: verilog/host_link_defines.svh */
`ifndef HOST_LINK_DEFINES_SVH
`define HOST_LINK_DEFINES_SVH

// Clock and serial rates
`define CLK_HZ         200000000
`define BAUD_FAST      115200
`define BAUD_SLOW      19200
`define BAUD_DIV_FAST  (`CLK_HZ / `BAUD_FAST)
`define BAUD_DIV_SLOW  (`CLK_HZ / `BAUD_SLOW)

// Answer deadline, minus room for sending the answer itself
`define ANS_LIMIT_MS   250
`define ANS_MARGIN_MS  10
`define ANS_WAIT_CYC   ((`CLK_HZ / 1000) * (`ANS_LIMIT_MS - `ANS_MARGIN_MS))

// Packet layout
`define MAX_PAYLOAD    22
`define PING_MAX       16
`define RPT_MAX        4
`define CLS_CMD        2'h0
`define CLS_RESP       2'h1
`define CLS_RPT        2'h2
`define CLS_ERR        2'h3
`define CODE_PING      6'h00
`define CODE_BAUD      6'h21
`define RPT_ITEMS      3

// Reflected CRC-16, complemented on the wire
`define CRC_INIT       16'hFFFF
`define CRC_POLY       16'h8408

`endif

/* File: verilog/host_link_pkg.sv */
package host_link_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        R_TYPE, R_LEN, R_DATA, R_CRCL, R_CRCH
    } rx_state_t;
    typedef enum logic [2:0] {
        T_IDLE, T_TYPE, T_LEN, T_DATA, T_CRCL, T_CRCH
    } tx_state_t;
endpackage

/* File: verilog/payload_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module payload_mem #(
    parameter int unsigned DEPTH = 22,
    parameter int unsigned AW    = 5
) (
    input  wire logic          sys_clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [7:0]    rdata_o
);
    logic [7:0] mem_q [DEPTH];

    // Write port
    always_ff @(posedge sys_clk_i) begin
        if (we_i && (32'(waddr_i) < DEPTH)) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // Registered read port
    always_ff @(posedge sys_clk_i) begin
        rdata_o <= (32'(raddr_i) < DEPTH) ? mem_q[raddr_i] : 8'h00;
    end
endmodule // payload_mem
`default_nettype wire

/* File: verilog/skid_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
module skid_buffer #(
    parameter int unsigned WIDTH = 41,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             sys_clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] slot_q [DEPTH];
    logic [PW-1:0]    wr_q, rd_q;
    logic [PW:0]      cnt_q;
    logic             push, pop;

    assign in_ready_o  = (32'(cnt_q) < DEPTH);
    assign out_valid_o = (cnt_q != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = slot_q[rd_q];

    // Storage
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            slot_q[wr_q] <= in_data_i;
        end
    end

    // Pointers and fill count
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (32'(wr_q) == DEPTH - 1) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (32'(rd_q) == DEPTH - 1) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // skid_buffer
`default_nettype wire

/* File: tb/host_uart_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_uart_model #(
    parameter int DF = 8,
    parameter int DS = 16
) (
    input  wire logic sys_clk_i,
    input  wire logic tx_i,
    input  wire logic slow_i,
    output logic      rx_o
);
    logic [7:0] got_q[$];
    // Line rests at its idle level outside frames
    initial rx_o = 1'b1;
    // One 8N1 character, low bit first
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_o <= f[i];
            repeat (slow_i ? DS : DF) @(posedge sys_clk_i);
        end
    endtask
    // Host input buffer, drained at once
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge tx_i);
            repeat ((slow_i ? DS : DF) / 2) @(posedge sys_clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (slow_i ? DS : DF) @(posedge sys_clk_i);
                b[i] = tx_i;
            end
            repeat (slow_i ? DS : DF) @(posedge sys_clk_i);
            got_q.push_back(b);
        end
    end
endmodule // host_uart_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import host_link_pkg::*;
    logic        sys_clk, arst_n, rx, tx, cmd_valid, ans_valid, ans_ok;
    logic        rpt_valid, rpt_ready, baud_slow, rx_drop;
    logic [5:0]  cmd_code, rpt_code;
    logic [4:0]  cmd_len;
    logic [2:0]  rpt_en, rpt_len;
    logic [31:0] rpt_data;
    int          error_cnt, tests_run, drops;
    host_packet_link #(.DIV_FAST(8), .DIV_SLOW(16), .ANS_WAIT(2000)) dut (
        .sys_clk_i(sys_clk), .arst_n_i(arst_n), .rx_i(rx), .tx_o(tx),
        .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .cmd_len_o(cmd_len),
        .ans_valid_i(ans_valid), .ans_ok_i(ans_ok), .rpt_en_i(rpt_en),
        .rpt_valid_i(rpt_valid), .rpt_ready_o(rpt_ready),
        .rpt_code_i(rpt_code), .rpt_len_i(rpt_len), .rpt_data_i(rpt_data),
        .baud_slow_o(baud_slow), .rx_drop_o(rx_drop));
    host_uart_model #(.DF(8), .DS(16)) m (.sys_clk_i(sys_clk), .tx_i(tx),
        .slow_i(baud_slow), .rx_o(rx));
    // Clock and counting of dropped packets
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (rx_drop === 1'b1) drops++;
    task automatic check(string w, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %0h got %0h", w, e, g);
        end
    endtask
    function automatic logic [15:0] crc16(input byte_t q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
        end
        return ~c;
    endfunction
    task automatic send_pkt(input byte_t q[$], input logic [15:0] flip);
        logic [15:0] c;
        c = crc16(q) ^ flip;
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) m.send(q[i]);
    endtask
    task automatic expect_pkt(input byte_t q[$]);
        logic [15:0] c;
        byte_t       g;
        c = crc16(q);
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        for (int i = 0; i < 4000 && m.got_q.size() < q.size(); i++)
            @(posedge sys_clk);
        foreach (q[i]) begin
            g = (m.got_q.size() > i) ? m.got_q[i] : 'x;
            check("tx byte", q[i], g);
        end
        m.got_q.delete();
    endtask
    task automatic t_ping();
        send_pkt('{8'h00, 8'h02, 8'hAA, 8'hBB}, 16'h0000);
        expect_pkt('{8'h40, 8'h02, 8'hAA, 8'hBB});
    endtask
    task automatic t_bad();
        int d;
        d = drops;
        m.send(8'h00);
        m.send(8'h17);
        send_pkt('{8'h00, 8'h01, 8'h55}, 16'h0100);
        repeat (300) @(posedge sys_clk);
        check("drops", d + 2, drops);
        check("no answer", 0, m.got_q.size());
        send_pkt('{8'h00, 8'h01, 8'h55}, 16'h0000);
        expect_pkt('{8'h40, 8'h01, 8'h55});
    endtask
    task automatic t_cmd(input logic [5:0] code, input bit give, input bit ok);
        send_pkt('{{2'b00, code}, 8'h00}, 16'h0000);
        for (int i = 0; i < 300 && cmd_valid !== 1'b1; i++)
            @(posedge sys_clk);
        check("cmd code", code, cmd_code);
        check("cmd len", 0, cmd_len);
        if (give) begin
            ans_valid <= 1'b1;
            ans_ok <= ok;
            @(posedge sys_clk);
            ans_valid <= 1'b0;
        end
        expect_pkt('{{give && ok ? 2'b01 : 2'b11, code}, 8'h00});
    endtask
    task automatic t_rpt(input logic [2:0] en, input bit sent);
        rpt_en <= en;
        rpt_valid <= 1'b1;
        do @(posedge sys_clk); while (rpt_ready !== 1'b1);
        rpt_valid <= 1'b0;
        if (sent) expect_pkt('{8'h81, 8'h02, 8'hAA, 8'hBB});
        else begin
            repeat (1000) @(posedge sys_clk);
            check("muted report", 0, m.got_q.size());
        end
    endtask
    task automatic t_baud();
        send_pkt('{8'h21, 8'h01, 8'h07}, 16'h0000);
        expect_pkt('{8'hE1, 8'h00});
        send_pkt('{8'h21, 8'h01, 8'h01}, 16'h0000);
        expect_pkt('{8'h61, 8'h00});
        repeat (50) @(posedge sys_clk);
        check("slow", 1, baud_slow);
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Watchdog over the whole run
    initial begin
        #400000;
        error_cnt++;
        summarize();
    end
    // Main sequence
    initial begin
        {arst_n, ans_valid, ans_ok, rpt_valid} = '0;
        {rpt_en, rpt_code, rpt_len} = {3'h0, 6'h01, 3'h2};
        rpt_data = 32'h0000BBAA;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
        t_ping();
        t_bad();
        t_cmd(6'h05, 1, 0);
        t_cmd(6'h0A, 1, 1);
        t_cmd(6'h07, 0, 0);
        t_rpt(3'h2, 1);
        t_rpt(3'h5, 0);
        t_baud();
        t_ping();
        summarize();
    end
endmodule // tb
`default_nettype wire
